// file: logic/cmp_ctrl_pkg.sv
// package: register map, field layout and encodings of the cell comparator control block
// ****************************************************************
// Summary of operation
// - held threshold select: 0 holds undervoltage, 1 holds balancing-done threshold
// - held threshold select is used only when mode is single-channel lock
// - channel field codes 0x0..0x5 pick cells 1..6; 0x6..0xF reserved
// - new channel value applies only when written in the same write as the launch bit
// - launch write starts comparators and samples mode, channel and threshold select; mask and active count apply without a launch
// - launch bit self-clears and reads back 0 meaning ready
// - set mask bit excludes that cell from undervoltage and balancing-done detection
// ****************************************************************
package cmp_ctrl_pkg;
  // offsets are word indices: one 32-bit word per register, byte address is four times it
  localparam logic [11:0] ctrl_offset = 12'h32C;
  localparam logic [11:0] mask_offset = 12'h00D;
  localparam logic [11:0] active_offset = 12'h330;
  localparam logic [11:0] status_offset = 12'h334;
  localparam logic [11:0] ctrl_addr = {ctrl_offset[9:0], 2'b00};
  localparam logic [11:0] mask_addr = {mask_offset[9:0], 2'b00};
  localparam logic [11:0] active_addr = {active_offset[9:0], 2'b00};
  localparam logic [11:0] status_addr = {status_offset[9:0], 2'b00};
  localparam int mode_lsb = 0;
  localparam int launch_bit = 2;
  localparam int chan_lsb = 3;
  localparam int thr_bit = 7;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [5:0] mask_reset = 6'h00;
  localparam logic [2:0] active_reset = 3'h5;
  localparam logic [3:0] last_cell_code = 4'h5;
  localparam int num_cells = 6;
  localparam int self_test_cycles = 16;
  typedef enum logic [1:0] {
    mode_off = 2'h0,
    mode_round_robin = 2'h1,
    mode_self_test = 2'h2,
    mode_single = 2'h3
  } comparator_mode_t;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : cmp_ctrl_pkg

// file: logic/cmp_sequencer.sv
// comparator channel sequencer: drives the selected cell for each mode
`timescale 1ns/1ps
module cmp_sequencer
  import cmp_ctrl_pkg::*;
#(
  parameter int cells = num_cells
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire cmp_ctrl_pkg::comparator_mode_t mode,
  input wire logic [3:0] lock_chan,
  input wire logic [2:0] active_last,
  output logic [3:0] chan_q,
  output logic running_q,
  output logic built_in_self_test_busy_q
);
  logic [4:0] built_in_self_test_cnt_q;

  // ****************************************************************
  // channel stepping
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chan_q <= 4'h0;
      running_q <= 1'b0;
    end else if (start) begin
      running_q <= (mode != mode_off);
      chan_q <= (mode == mode_single) ? lock_chan : 4'h0;
    end else if (running_q && mode == mode_round_robin) begin
      // wrap at the last active cell so unused inputs never get visited
      if (chan_q >= {1'b0, active_last} || chan_q >= 4'(cells - 1)) begin
        chan_q <= 4'h0;
      end else begin
        chan_q <= chan_q + 4'h1;
      end
    end else if (running_q && mode == mode_self_test) begin
      if (built_in_self_test_cnt_q == 5'(self_test_cycles - 1)) begin
        running_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      built_in_self_test_cnt_q <= 5'h00;
      built_in_self_test_busy_q <= 1'b0;
    end else if (start) begin
      built_in_self_test_cnt_q <= 5'h00;
      built_in_self_test_busy_q <= (mode == mode_self_test);
    end else if (built_in_self_test_busy_q) begin
      built_in_self_test_cnt_q <= built_in_self_test_cnt_q + 5'h01;
      if (built_in_self_test_cnt_q == 5'(self_test_cycles - 1)) begin
        built_in_self_test_busy_q <= 1'b0;
      end
    end
  end
endmodule : cmp_sequencer

// file: logic/cell_comparator_control.sv
// top: axi4-lite register bank for the cell over/undervoltage comparator control
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module cell_comparator_control (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] cmp_channel_q,
  output logic cmp_running_q,
  output logic built_in_self_test_busy_q,
  output logic held_threshold_q,
  output logic [5:0] uv_enable_q,
  output logic [1:0] active_mode_q
);
  import cmp_ctrl_pkg::*;

  logic [7:0] ctrl_q;
  logic [5:0] mask_q;
  logic [2:0] active_q;
  logic [11:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic w_have_q;
  logic launch_q;
  logic [3:0] chan_sampled_q;
  logic thr_sampled_q;
  comparator_mode_t mode_sampled_q;
  logic [3:0] seq_chan;
  logic seq_run;
  logic seq_built_in_self_test;
  logic wr_go;
  logic wr_lane0;
  logic launch_wr;
  logic wr_ctrl_hit;
  logic wr_mask_hit;
  logic wr_active_hit;
  logic wr_known;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;

  // ****************************************************************
  // write channel capture
  // ****************************************************************
  // address and data may arrive in either order; each is held until both exist
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_lane0 = wr_go && ws_q[0];
  assign launch_wr = wr_lane0 && wr_ctrl_hit && w_q[launch_bit];

  // only whole aligned words decode, so a byte address inside a word never aliases
  always_comb begin
    wr_ctrl_hit = 1'b0;
    wr_mask_hit = 1'b0;
    wr_active_hit = 1'b0;
    wr_known = 1'b1;
    case (aw_q)
      ctrl_addr: wr_ctrl_hit = 1'b1;
      mask_addr: wr_mask_hit = 1'b1;
      active_addr: wr_active_hit = 1'b1;
      status_addr: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_q <= s_axi_awaddr;
    end
  end

  // ready stays low from capture until the response is gone: one write at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (!aw_have_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_have_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_q <= s_axi_wdata;
      ws_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (!w_have_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unmapped words answer with an error and store nothing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bresp <= resp_okay;
    end else if (wr_go) begin
      s_axi_bresp <= wr_known ? resp_okay : resp_slverr;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= ctrl_reset;
    end else if (wr_lane0 && wr_ctrl_hit) begin
      // launch is never stored, so it reads back 0 meaning ready
      ctrl_q <= w_q[7:0] & ~(8'h01 << launch_bit);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= mask_reset;
    end else if (wr_lane0 && wr_mask_hit) begin
      mask_q <= w_q[5:0];
    end
  end

  // a count beyond the last input is clamped, so round robin never walks off the end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_q <= active_reset;
    end else if (wr_lane0 && wr_active_hit) begin
      active_q <= (w_q[2:0] > last_cell_code[2:0]) ? last_cell_code[2:0] : w_q[2:0];
    end
  end

  // ****************************************************************
  // launch sampling
  // ****************************************************************
  // configuration is captured from the write data itself, so a launch together
  // with new fields applies them in the same write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      launch_q <= 1'b0;
      chan_sampled_q <= 4'h0;
      thr_sampled_q <= 1'b0;
      mode_sampled_q <= mode_off;
    end else begin
      launch_q <= launch_wr;
      if (launch_wr) begin
        mode_sampled_q <= comparator_mode_t'(w_q[mode_lsb +: 2]);
        chan_sampled_q <= w_q[chan_lsb +: 4];
        // reserved codes fall back to cell 1 rather than an absent input
        if (w_q[chan_lsb +: 4] > last_cell_code) begin
          chan_sampled_q <= 4'h0;
        end
        // threshold select matters only in single-channel lock
        thr_sampled_q <= (w_q[mode_lsb +: 2] == mode_single) ? w_q[thr_bit] : 1'b0;
      end
    end
  end

  cmp_sequencer #(
    .cells(num_cells)
  ) u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(launch_q),
    .mode(mode_sampled_q),
    .lock_chan(chan_sampled_q),
    .active_last(active_q),
    .chan_q(seq_chan),
    .running_q(seq_run),
    .built_in_self_test_busy_q(seq_built_in_self_test)
  );

  // ****************************************************************
  // comparator outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp_channel_q <= 4'h0;
      cmp_running_q <= 1'b0;
      built_in_self_test_busy_q <= 1'b0;
    end else begin
      cmp_channel_q <= seq_chan;
      cmp_running_q <= seq_run;
      built_in_self_test_busy_q <= seq_built_in_self_test;
    end
  end

  // mode and threshold follow the launch sample directly, a cycle ahead of the channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      held_threshold_q <= 1'b0;
      active_mode_q <= 2'h0;
    end else begin
      held_threshold_q <= thr_sampled_q;
      active_mode_q <= mode_sampled_q;
    end
  end

  generate
    for (genvar i = 0; i < num_cells; i++) begin : g_mask
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          uv_enable_q[i] <= 1'b0;
        end else begin
          uv_enable_q[i] <= !mask_q[i] && i <= int'(active_q);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read channel
  // ****************************************************************
  // the word is picked at the request and frozen until rready takes it
  always_comb begin
    rdata_d = 32'h0000_0000;
    rresp_d = resp_okay;
    case (s_axi_araddr)
      ctrl_addr: rdata_d = {24'h000000, ctrl_q};
      mask_addr: rdata_d = {26'h0000000, mask_q};
      active_addr: rdata_d = {29'h00000000, active_q};
      status_addr: rdata_d = {24'h000000, cmp_channel_q, built_in_self_test_busy_q, cmp_running_q,
                              active_mode_q};
      default: rresp_d = resp_slverr;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end
endmodule : cell_comparator_control

// file: bench/cell_comparator_control_monitor.sv
// checker: bus and comparator control relations at the block boundary
`timescale 1ns/1ps
module cell_comparator_control_monitor
  import cmp_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] cmp_channel_q,
  input wire logic cmp_running_q,
  input wire logic built_in_self_test_busy_q,
  input wire logic held_threshold_q,
  input wire logic [1:0] active_mode_q
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  wr_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("read answer missing");
  rd_refuse_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  thr_mode_a: assert property (
    held_threshold_q |-> active_mode_q == mode_single) else $error("threshold held off mode");
  chan_range_a: assert property (
    cmp_channel_q <= last_cell_code) else $error("channel out of range");
  lock_hold_a: assert property (
    (cmp_running_q && active_mode_q == mode_single && !s_axi_wvalid) [*4] |=>
    $stable(cmp_channel_q)) else $error("locked channel moved");
  built_in_self_test_len_a: assert property (
    $rose(built_in_self_test_busy_q) |-> ##[14:18] !built_in_self_test_busy_q) else $error("self test length");
  off_stop_a: assert property (
    (active_mode_q == mode_off) [*3] |-> !cmp_running_q) else $error("running while off");
  built_in_self_test_c: cover property ($rose(built_in_self_test_busy_q));
  single_c: cover property (cmp_running_q && active_mode_q == mode_single);
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == resp_slverr);
endmodule : cell_comparator_control_monitor

bind cell_comparator_control cell_comparator_control_monitor mon_u (.clk, .sys_rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .cmp_channel_q, .cmp_running_q,
  .built_in_self_test_busy_q, .held_threshold_q, .active_mode_q);

// file: bench/cell_comparator_control_tb.sv
// testbench: register access and launch behaviour of the comparator control
`timescale 1ns/1ps
module cell_comparator_control_tb;
  import cmp_ctrl_pkg::*;
  logic clk = 0, sys_rst = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, cmp_channel_q, seen;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmp_running_q, built_in_self_test_busy_q, held_threshold_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, active_mode_q;
  logic [5:0] uv_enable_q;
  int bad_count = 0, tests_run = 0, cyc = 0;
  cell_comparator_control dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_channel_q,
    .cmp_running_q, .built_in_self_test_busy_q, .held_threshold_q, .uv_enable_q, .active_mode_q);
  // ****************************************************************
  // clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    forever #25 clk = ~clk;
  end
  // a hung handshake would stall the run, so a cycle ceiling ends it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awready && !aw) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready && !w) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    // bready stays high afterwards, so back-to-back calls never toggle it in one step
    do @(posedge clk); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd
  task automatic go(input logic [7:0] d);
    wr(ctrl_addr, d, resp_okay);
    repeat (4) @(posedge clk);
  endtask : go
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(ctrl_addr, 32'h00, resp_okay);
    rd(mask_addr, 32'h00, resp_okay);
    rd(12'h100, 32'h00, resp_slverr);
    wr(12'h100, 8'hFF, resp_slverr);
    chk({26'h0, uv_enable_q}, 32'h3F);
  endtask : t_reset
  task automatic t_single();
    for (int c = 0; c < 6; c++) begin
      go({1'b1, c[3:0], 3'b111});
      chk({28'h0, cmp_channel_q}, c);
      chk({29'h0, held_threshold_q, active_mode_q}, 32'h7);
      chk({31'h0, cmp_running_q}, 32'h1);
      rd(ctrl_addr, {24'h0, 1'b1, c[3:0], 3'b011}, resp_okay);
    end
    wr(ctrl_addr, 8'h13, resp_okay);
    repeat (4) @(posedge clk);
    chk({28'h0, cmp_channel_q}, 32'h5);
    go(8'h37);
    chk({27'h0, cmp_channel_q, held_threshold_q}, 32'h0);
  endtask : t_single
  task automatic t_modes();
    go(8'h85);
    chk({29'h0, held_threshold_q, active_mode_q}, 32'h1);
    wr(active_addr, 8'h02, resp_okay);
    go(8'h05);
    seen = 0;
    repeat (8) begin
      @(posedge clk);
      seen[cmp_channel_q[1:0]] = 1'b1;
      chk({31'h0, cmp_channel_q <= 4'h2}, 32'h1);
    end
    chk({28'h0, seen}, 32'h7);
    wr(mask_addr, 8'h05, resp_okay);
    repeat (3) @(posedge clk);
    chk({26'h0, uv_enable_q}, 32'h02);
    go(8'h06);
    chk({30'h0, built_in_self_test_busy_q, cmp_running_q}, 32'h3);
    repeat (20) @(posedge clk);
    chk({30'h0, built_in_self_test_busy_q, cmp_running_q}, 32'h0);
    go(8'h07);
    go(8'h04);
    chk({30'h0, active_mode_q}, 32'h0);
    chk({31'h0, cmp_running_q}, 32'h0);
  endtask : t_modes
  task automatic t_regs();
    wr(active_addr, 8'h07, resp_okay);
    rd(active_addr, 32'h05, resp_okay);
    go(8'h9F);
    rd(status_addr, 32'h37, resp_okay);
    chk({26'h0, uv_enable_q}, 32'h3A);
    s_axi_wstrb <= 4'hE;
    wr(mask_addr, 8'h3F, resp_okay);
    s_axi_wstrb <= 4'hF;
    rd(mask_addr, 32'h05, resp_okay);
  endtask : t_regs
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    t_reset();
    t_single();
    t_modes();
    t_regs();
    test_done();
  end
endmodule : cell_comparator_control_tb
